// *** verilog/tx_path_map.svh ***
// Purpose: Register offsets, reset values, field positions and counts
// Assumes: 8-bit register port, printed offsets used directly
// Notes:   Definitions only
`ifndef TX_PATH_MAP_SVH
`define TX_PATH_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_IDLE_ASSERT 8'h91
`define OFS_IDLE_CLEAR 8'h92
`define OFS_PHASE 8'h98
`define OFS_EYE_READ 8'h99
`define OFS_EYE_CFG 8'h9a
`define OFS_EYE_REL 8'h9b
`define OFS_PATH_CFG 8'h9c
`define OFS_EVT_STATUS 8'ha0
`define OFS_EVT_CLEAR 8'ha1
`define OFS_EVT_ENABLE 8'ha2
`define OFS_LIVE_STATUS 8'ha3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_IDLE_ASSERT 8'h00
`define RST_IDLE_CLEAR 8'h00
`define RST_PHASE 7'h00
`define RST_EYE_CFG 8'h05
`define RST_EYE_REL 6'h08
`define RST_PATH_CFG 7'h00
`define RST_EVT_ENABLE 4'h0

// ------------------------------------------------------------
// Fields of the path configuration register
// ------------------------------------------------------------
`define PATH_INVERT 6
`define PATH_CLK_SUB 5
`define PATH_MUTE_LOL 4
`define PATH_MUTE_LOS 3
`define PATH_MUTE_ALL 2
`define PATH_AUTO_RECOVER 1
`define PATH_MANUAL_CLEAR 0

// Assert level sits in bits 7:2 of the eye-quality config
`define EYE_LVL_MSB 7
`define EYE_LVL_LSB 2

// Event bits of status, clear and enable
`define EVT_IDLE_SET 0
`define EVT_IDLE_REL 1
`define EVT_EYE_SET 2
`define EVT_FIFO_ERR 3
`define EVT_N 4

// Cycles until every synchroniser stage holds a sampled pin value
`define PIN_SETTLE 3'h4

// ------------------------------------------------------------
// Idle-line detector arithmetic
// ------------------------------------------------------------
`define IDLE_ASSERT_MUL 5
`define IDLE_ASSERT_ADD 2
`define IDLE_CLEAR_MUL 16
`define IDLE_CLEAR_ADD 1

`endif

// *** verilog/tx_path_pkg.sv ***
// Purpose: Shared types of the transmit monitor and path block
// Assumes: Offsets and counts come from tx_path_map.svh
// Notes:   Types only
package tx_path_pkg;
   typedef logic [7:0] reg_byte_type;
   typedef enum logic {IDLE_LINE_OK, IDLE_LINE_ALARM} idle_state_type;
endpackage : tx_path_pkg

// *** verilog/tx_signal_monitor_path_cfg.sv ***
// Purpose: Transmit control/status registers, idle-line and eye monitors,
//          output data path steering
// Assumes: One clock, one recovered data bit per cycle on tx_data_i
// Notes:   Analog pins pass a three-stage synchroniser
//
// Functional notes
// - Idle alarm releases after clear*16+1 busy blocks
// - Phase offset is 7-bit two's complement
// - Eye reading is 6-bit magnitude, 0 smallest
// - Assert level in config bits 7:2, default 1
// - Eye alarm releases at release level, default 8
// - Polarity bit inverts serial output
// - Clock substitute bit sends clock on loss
// - Mute output on lock loss when enabled
// - Mute output on signal loss when enabled
// - Forced mute squelches output unconditionally
// - Auto recover clears FIFO on error
// - Manual clear bit holds FIFO cleared
// - Eye flag below threshold; lock loss forces zero
// - Idle alarm after (assert*5+2)*1024 identical bits
`include "tx_path_map.svh"

module tx_signal_monitor_path_cfg
   import tx_path_pkg::*;
#(
   parameter int BLOCK_BITS = 1024,
   parameter int RUN_W = 24,
   parameter int GOOD_W = 13
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Recovered data and FIFO status, same clock
   input wire logic tx_data_i,
   input wire logic fifo_error_i,
   // Analog monitors, asynchronous
   input wire logic signal_loss_i,
   input wire logic lock_loss_i,
   input wire logic [5:0] eye_opening_i,
   // Output path
   output logic tx_serial_out_o,
   output logic clock_substitute_o,
   output logic buffer_clear_o,
   output logic [6:0] tx_phase_offset_o,
   // Alarms and interrupt
   output logic digital_idle_alarm_o,
   output logic eye_quality_loss_flag_o,
   output logic irq_o
);

   localparam int BLK_W = $clog2(BLOCK_BITS);
   localparam int PIN_N = 8;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg_byte_type idle_assert_q;
   reg_byte_type idle_clear_q;
   logic [6:0] phase_q;
   reg_byte_type eye_cfg_q;
   logic [5:0] eye_rel_q;
   logic [6:0] path_q;
   logic [`EVT_N-1:0] evt_status_q;
   logic [`EVT_N-1:0] evt_enable_q;
   logic [`EVT_N-1:0] evt_set;
   logic [`EVT_N-1:0] evt_clr;
   reg_byte_type rdata_q;

   // Synchronised pins
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_s1_q;
   logic [PIN_N-1:0] pin_s2_q;
   logic [PIN_N-1:0] pin_s3_q;
   logic [PIN_N-1:0] pin_q;
   logic los_pin;
   logic lol_pin;
   logic [5:0] eye_val;
   logic [2:0] settle_q;
   logic pins_ok;

   // Idle-line detector
   idle_state_type idle_state_q;
   logic bit_prev_q;
   logic last_trigger_q;
   logic [RUN_W-1:0] run_q;
   logic [RUN_W-1:0] run_d;
   logic [RUN_W-1:0] assert_bits;
   logic [BLK_W-1:0] blk_pos_q;
   logic blk_trans_q;
   logic blk_end;
   logic blk_busy;
   logic [GOOD_W-1:0] good_q;
   logic [GOOD_W-1:0] good_d;
   logic [GOOD_W-1:0] clear_blocks;

   // Eye monitor and path
   logic eye_flag_q;
   logic [5:0] eye_assert_lvl;
   logic tx_los;
   logic mute;

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   assign pin_raw = {eye_opening_i, lock_loss_i, signal_loss_i};

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // A change counts only once two stages agree, filtering one-cycle glitches
   generate
      for (genvar i = 0; i < PIN_N; i++) begin : g_pin
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pin_q[i] <= 1'b0;
            end else if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_q[i] <= pin_s3_q[i];
            end
         end
      end
   endgenerate

   assign los_pin = pin_q[0];
   assign lol_pin = pin_q[1];
   assign eye_val = pin_q[7:2];

   // Pins read zero until the stages fill; an eye reading of zero
   // would otherwise raise a false eye alarm straight after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_q <= '0;
      end else if (!pins_ok) begin
         settle_q <= settle_q + 3'h1;
      end
   end

   assign pins_ok = (settle_q == `PIN_SETTLE);

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Writes to read-only offsets are dropped silently
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_assert_q <= `RST_IDLE_ASSERT;
         idle_clear_q <= `RST_IDLE_CLEAR;
         phase_q <= `RST_PHASE;
         eye_cfg_q <= `RST_EYE_CFG;
         eye_rel_q <= `RST_EYE_REL;
         path_q <= `RST_PATH_CFG;
         evt_enable_q <= `RST_EVT_ENABLE;
      end else if (wr_i) begin
         unique case (addr_i)
            `OFS_IDLE_ASSERT: idle_assert_q <= wdata_i;
            `OFS_IDLE_CLEAR: idle_clear_q <= wdata_i;
            `OFS_PHASE: phase_q <= wdata_i[6:0];
            `OFS_EYE_CFG: eye_cfg_q <= wdata_i; // Low bits kept as written
            `OFS_EYE_REL: eye_rel_q <= wdata_i[5:0];
            `OFS_PATH_CFG: path_q <= wdata_i[6:0];
            `OFS_EVT_ENABLE: evt_enable_q <= wdata_i[`EVT_N-1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   // Data stands in the cycle after the strobe only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            `OFS_IDLE_ASSERT: rdata_q <= idle_assert_q;
            `OFS_IDLE_CLEAR: rdata_q <= idle_clear_q;
            `OFS_PHASE: rdata_q <= {1'b0, phase_q};
            `OFS_EYE_READ: rdata_q <= {2'b00, eye_val};
            `OFS_EYE_CFG: rdata_q <= eye_cfg_q;
            `OFS_EYE_REL: rdata_q <= {2'b00, eye_rel_q};
            `OFS_PATH_CFG: rdata_q <= {1'b0, path_q};
            `OFS_EVT_STATUS: rdata_q <= {{(8-`EVT_N){1'b0}}, evt_status_q};
            `OFS_EVT_ENABLE: rdata_q <= {{(8-`EVT_N){1'b0}}, evt_enable_q};
            `OFS_LIVE_STATUS: rdata_q <= {4'h0, last_trigger_q, eye_flag_q,
                                          idle_state_q == IDLE_LINE_ALARM, tx_los};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_o = rdata_q;

   // ------------------------------------------------------------
   // Idle-line detector
   // ------------------------------------------------------------
   // Thresholds in bits and blocks, widened before the multiply
   assign assert_bits = (RUN_W'(idle_assert_q) * RUN_W'(`IDLE_ASSERT_MUL)
                         + RUN_W'(`IDLE_ASSERT_ADD)) * RUN_W'(BLOCK_BITS);
   assign clear_blocks = GOOD_W'(idle_clear_q) * GOOD_W'(`IDLE_CLEAR_MUL)
                         + GOOD_W'(`IDLE_CLEAR_ADD);

   // Run length saturates so a long dead line cannot wrap back to zero
   always_comb begin
      if (tx_data_i != bit_prev_q) begin
         run_d = RUN_W'(1);
      end else if (&run_q) begin
         run_d = run_q;
      end else begin
         run_d = run_q + RUN_W'(1);
      end
   end

   assign blk_end = (blk_pos_q == BLK_W'(BLOCK_BITS - 1));
   assign blk_busy = blk_trans_q | (tx_data_i != bit_prev_q);

   // A block with no transition restarts the release count
   always_comb begin
      if (!blk_busy) begin
         good_d = '0;
      end else if (&good_q) begin
         good_d = good_q;
      end else begin
         good_d = good_q + GOOD_W'(1);
      end
   end

   // Bit history, run length and block position
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_prev_q <= 1'b0;
         run_q <= '0;
         blk_pos_q <= '0;
         blk_trans_q <= 1'b0;
      end else begin
         bit_prev_q <= tx_data_i;
         run_q <= run_d;
         blk_pos_q <= blk_end ? '0 : blk_pos_q + BLK_W'(1);
         blk_trans_q <= blk_end ? 1'b0 : blk_busy;
      end
   end

   // Block count only matters while the alarm stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         good_q <= '0;
      end else if (idle_state_q == IDLE_LINE_OK) begin
         good_q <= '0;
      end else if (blk_end) begin
         good_q <= good_d;
      end
   end

   // Alarm state and the bit value that triggered it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_state_q <= IDLE_LINE_OK;
         last_trigger_q <= 1'b0;
      end else begin
         unique case (idle_state_q)
            IDLE_LINE_OK: begin
               if (run_d >= assert_bits) begin
                  idle_state_q <= IDLE_LINE_ALARM;
                  last_trigger_q <= tx_data_i;
               end
            end
            IDLE_LINE_ALARM: begin
               if (blk_end && good_d >= clear_blocks) begin
                  idle_state_q <= IDLE_LINE_OK;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Eye-quality monitor
   // ------------------------------------------------------------
   assign eye_assert_lvl = eye_cfg_q[`EYE_LVL_MSB:`EYE_LVL_LSB];

   // Hysteresis: raised below assert level, dropped at release level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eye_flag_q <= 1'b0;
      end else if (!pins_ok) begin
         eye_flag_q <= 1'b0;
      end else if (lol_pin) begin
         eye_flag_q <= 1'b0;
      end else if (!eye_flag_q && eye_val < eye_assert_lvl) begin
         eye_flag_q <= 1'b1;
      end else if (eye_flag_q && eye_val >= eye_rel_q) begin
         eye_flag_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Output data path
   // ------------------------------------------------------------
   assign tx_los = los_pin | (idle_state_q == IDLE_LINE_ALARM);
   assign mute = path_q[`PATH_MUTE_ALL]
                 | (path_q[`PATH_MUTE_LOL] & lol_pin)
                 | (path_q[`PATH_MUTE_LOS] & tx_los);

   // Mute beats clock substitution, so a squelched line stays quiet
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_serial_out_o <= 1'b0;
         clock_substitute_o <= 1'b0;
      end else begin
         tx_serial_out_o <= mute ? 1'b0 : tx_data_i ^ path_q[`PATH_INVERT];
         clock_substitute_o <= !mute && path_q[`PATH_CLK_SUB] && tx_los;
      end
   end

   // Auto clear lasts one cycle per error, manual clear holds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buffer_clear_o <= 1'b0;
      end else begin
         buffer_clear_o <= path_q[`PATH_MANUAL_CLEAR]
                           | (path_q[`PATH_AUTO_RECOVER] & fifo_error_i);
      end
   end

   // Signed offset passed on unchanged for the phase interpolator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_phase_offset_o <= `RST_PHASE;
      end else begin
         tx_phase_offset_o <= phase_q;
      end
   end

   assign digital_idle_alarm_o = (idle_state_q == IDLE_LINE_ALARM);
   assign eye_quality_loss_flag_o = eye_flag_q;

   // ------------------------------------------------------------
   // Events and interrupt
   // ------------------------------------------------------------
   assign evt_set[`EVT_IDLE_SET] = (idle_state_q == IDLE_LINE_OK) && (run_d >= assert_bits);
   assign evt_set[`EVT_IDLE_REL] = (idle_state_q == IDLE_LINE_ALARM) && blk_end
                                   && (good_d >= clear_blocks);
   assign evt_set[`EVT_EYE_SET] = pins_ok && !lol_pin && !eye_flag_q
                                  && (eye_val < eye_assert_lvl);
   assign evt_set[`EVT_FIFO_ERR] = fifo_error_i;
   assign evt_clr = (wr_i && addr_i == `OFS_EVT_CLEAR) ? wdata_i[`EVT_N-1:0] : '0;

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_status_q <= '0;
      end else begin
         evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      end
   end

   assign irq_o = |(evt_status_q & evt_enable_q);

endmodule : tx_signal_monitor_path_cfg

// *** test/tx_path_props.sv ***
// Purpose: Port-level checks of the transmit monitor and path block
// Assumes: Register writes mirrored from the port; one clock domain
// Notes:   Bound to every instance of the block
`include "tx_path_map.svh"

module tx_path_props #(
   parameter int BLOCK_BITS = 1024
) (
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Data and monitor inputs
   input wire logic tx_data_i,
   input wire logic fifo_error_i,
   input wire logic lock_loss_i,
   // Observed outputs
   input wire logic tx_serial_out_o,
   input wire logic clock_substitute_o,
   input wire logic buffer_clear_o,
   input wire logic [6:0] tx_phase_offset_o,
   input wire logic digital_idle_alarm_o,
   input wire logic eye_quality_loss_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------
   // Mirrors
   // ---------------------------------
   logic [6:0] path_q, ph_q;
   logic [7:0] ac_q;
   logic [23:0] run_q;
   logic last_q;

   // Shadow of software writes, the ports give no other view
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         path_q <= 7'h00;
         ph_q <= 7'h00;
         ac_q <= 8'h00;
      end else if (wr_i) begin
         case (addr_i)
            `OFS_PATH_CFG: path_q <= wdata_i[6:0];
            `OFS_PHASE: ph_q <= wdata_i[6:0];
            `OFS_IDLE_ASSERT: ac_q <= wdata_i;
            default: ;
         endcase
      end
   end

   // Run of equal bits, current bit included
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 24'h000000;
         last_q <= 1'b0;
      end else begin
         last_q <= tx_data_i;
         run_q <= (run_q != 0 && tx_data_i == last_q) ? run_q + 1'b1 : 24'h000001;
      end
   end

   // ---------------------------------
   // Properties
   // ---------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_mute_forced:
      assert property ($past(path_q[2]) |-> !tx_serial_out_o) else $error("forced mute leaks");
   chk_data_invert:
      assert property (!$past(rst_i) && !$past(path_q[2]) && !$past(path_q[3])
         && !$past(path_q[4]) |-> tx_serial_out_o == ($past(tx_data_i) ^ $past(path_q[6])))
      else $error("serial output wrong");
   chk_buffer_clear:
      assert property (buffer_clear_o == ($past(path_q[0])
         | ($past(path_q[1]) & $past(fifo_error_i)))) else $error("buffer clear wrong");
   chk_clock_sub:
      assert property (clock_substitute_o |-> $past(path_q[5]) && !$past(path_q[2]))
      else $error("clock select without enable");
   chk_phase_follow:
      assert property (wr_i && addr_i == `OFS_PHASE ##1 !(wr_i && addr_i == `OFS_PHASE)
         |-> ##[0:1] tx_phase_offset_o == ph_q) else $error("phase output stale");
   chk_phase_read:
      assert property (rd_i && addr_i == `OFS_PHASE |=> rdata_o == {1'b0, $past(ph_q)})
      else $error("phase readback wrong");
   chk_reading_width:
      assert property (rd_i && addr_i == `OFS_EYE_READ |=> rdata_o[7:6] == 2'b00)
      else $error("eye reading too wide");
   chk_flag_lock:
      assert property (lock_loss_i [*8] |-> !eye_quality_loss_flag_o)
      else $error("eye flag during lock loss");
   chk_idle_run:
      assert property ($rose(digital_idle_alarm_o) |-> run_q >= (int'(ac_q) * 5 + 2) * BLOCK_BITS)
      else $error("idle alarm too early");
endmodule : tx_path_props

bind tx_signal_monitor_path_cfg tx_path_props #(.BLOCK_BITS(BLOCK_BITS)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .tx_data_i(tx_data_i), .fifo_error_i(fifo_error_i),
   .lock_loss_i(lock_loss_i), .tx_serial_out_o(tx_serial_out_o),
   .clock_substitute_o(clock_substitute_o), .buffer_clear_o(buffer_clear_o),
   .tx_phase_offset_o(tx_phase_offset_o), .digital_idle_alarm_o(digital_idle_alarm_o),
   .eye_quality_loss_flag_o(eye_quality_loss_flag_o));

// *** test/host_serializer.sv ***
// Purpose: Host serializer feeding the transmit serial input
// Assumes: One bit per clock, same domain as the block
// Notes:   Toggles or holds zero on request
module host_serializer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pattern select, high holds the line at zero
   input wire logic hold_i,
   // Serial data toward the block
   output logic data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Toggling gives every block a transition; holding starves it
   always_ff @(posedge clk_i) begin
      if (rst_i || hold_i) begin
         data_o <= 1'b0;
      end else begin
         data_o <= !data_o;
      end
   end
endmodule : host_serializer

// *** test/tb_top.sv ***
// Purpose: Directed bench of the transmit monitor and path block
// Assumes: Idle block shortened to 8 bits
// Notes:   Pins need a few cycles through the synchroniser
`include "tx_path_map.svh"

module tb_top import tx_path_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, hold = 1'b0;
   logic fifo_err = 1'b0, signal_loss_condition = 1'b0, lock_loss_condition = 1'b0, tx_data;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   reg_byte_type rdata;
   logic [5:0] eye = 6'h3f;
   logic [6:0] phase;
   logic out, csub, bclr, idle, flag, irq;
   int n_fail = 0, compares = 0;

   always #5 clk_i = !clk_i;

   host_serializer u_host (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .data_o(tx_data));
   tx_signal_monitor_path_cfg #(.BLOCK_BITS(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .tx_data_i(tx_data), .fifo_error_i(fifo_err), .signal_loss_i(signal_loss_condition),
      .lock_loss_i(lock_loss_condition), .eye_opening_i(eye), .tx_serial_out_o(out),
      .clock_substitute_o(csub), .buffer_clear_o(bclr), .tx_phase_offset_o(phase),
      .digital_idle_alarm_o(idle), .eye_quality_loss_flag_o(flag), .irq_o(irq));

   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input reg_byte_type seen, input reg_byte_type exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input reg_byte_type a, input reg_byte_type d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr

   // Read data stand only in the cycle after the strobe, taken at its closing edge
   task automatic rd(input reg_byte_type a, input reg_byte_type exp);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      chk(rdata, exp);
   endtask : rd

   function automatic logic pick(input int s);
      case (s)
         0: return flag;
         1: return idle;
         default: return csub;
      endcase
   endfunction : pick

   // Bounded wait; running out ends the run
   task automatic wait_for(input int s, input logic v, input int lim);
      for (int i = 0; i < lim && pick(s) !== v; i++) begin
         @(posedge clk_i);
      end
      chk(8'(pick(s)), 8'(v));
      if (pick(s) !== v) begin
         end_of_test();
      end
   endtask : wait_for

   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic reset_values();
      rd(`OFS_EYE_CFG, 8'h05);
      rd(`OFS_EYE_REL, 8'h08);
      rd(`OFS_IDLE_CLEAR, 8'h00);
      rd(`OFS_IDLE_ASSERT, 8'h00);
      rd(`OFS_PATH_CFG, 8'h00);
      rd(8'h97, 8'h00);
      rd(`OFS_EVT_STATUS, 8'h00);
   endtask : reset_values

   task automatic phase_case();
      wr(`OFS_PHASE, 8'hc1);
      rd(`OFS_PHASE, 8'h41);
      wr(`OFS_PHASE, 8'h3f);
      rd(`OFS_PHASE, 8'h3f);
      chk({1'b0, phase}, 8'h3f);
   endtask : phase_case

   task automatic eye_case();
      wr(`OFS_EYE_CFG, 8'h0d);
      rd(`OFS_EYE_CFG, 8'h0d);
      eye <= 6'h2a;
      repeat (6) @(posedge clk_i);
      rd(`OFS_EYE_READ, 8'h2a);
      wr(`OFS_EVT_ENABLE, 8'h04);
      eye <= 6'h02;
      wait_for(0, 1'b1, 12);
      chk(8'(irq), 8'h01);
      eye <= 6'h07;
      repeat (8) @(posedge clk_i);
      chk(8'(flag), 8'h01);
      eye <= 6'h08;
      wait_for(0, 1'b0, 12);
      wr(`OFS_EVT_CLEAR, 8'h04);
      chk(8'(irq), 8'h00);
      eye <= 6'h00;
      lock_loss_condition <= 1'b1;
      repeat (12) @(posedge clk_i);
      chk(8'(flag), 8'h00);
      wr(`OFS_EVT_ENABLE, 8'h00);
      lock_loss_condition <= 1'b0;
      wait_for(0, 1'b1, 12);
      chk(8'(irq), 8'h00);
      wr(`OFS_EVT_CLEAR, 8'h0f);
      eye <= 6'h3f;
      wait_for(0, 1'b0, 12);
   endtask : eye_case

   // Forced, lock-loss and signal-loss mutes against toggling data
   task automatic mute_case();
      logic ones;
      logic d;
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_PATH_CFG, i == 0 ? 8'h04 : (i == 1 ? 8'h10 : 8'h08));
         lock_loss_condition <= (i == 1);
         signal_loss_condition <= (i == 2);
         repeat (8) @(posedge clk_i);
         ones = 1'b0;
         repeat (4) begin
            @(posedge clk_i);
            ones = ones | out;
         end
         chk(8'(ones), 8'h00);
      end
      lock_loss_condition <= 1'b0;
      signal_loss_condition <= 1'b0;
      wr(`OFS_PATH_CFG, 8'h40);
      repeat (8) @(posedge clk_i);
      d = tx_data;
      @(posedge clk_i);
      chk(8'(out), 8'(!d));
      wr(`OFS_PATH_CFG, 8'h00);
   endtask : mute_case

   task automatic buffer_case();
      wr(`OFS_PATH_CFG, 8'h01);
      @(posedge clk_i);
      chk(8'(bclr), 8'h01);
      wr(`OFS_PATH_CFG, 8'h02);
      fifo_err <= 1'b1;
      @(posedge clk_i);
      fifo_err <= 1'b0;
      @(posedge clk_i);
      chk(8'(bclr), 8'h01);
      @(posedge clk_i);
      chk(8'(bclr), 8'h00);
      rd(`OFS_EVT_STATUS, 8'h08);
      wr(`OFS_EVT_CLEAR, 8'h08);
      wr(`OFS_PATH_CFG, 8'h00);
   endtask : buffer_case

   // Clear count 1 asks for 17 busy blocks of 8 bits
   task automatic idle_case();
      wr(`OFS_IDLE_CLEAR, 8'h01);
      hold <= 1'b1;
      wait_for(1, 1'b1, 40);
      rd(`OFS_LIVE_STATUS, 8'h03);
      rd(`OFS_EVT_STATUS, 8'h01);
      wr(`OFS_PATH_CFG, 8'h20);
      wait_for(2, 1'b1, 8);
      hold <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk(8'(idle), 8'h01);
      wait_for(1, 1'b0, 100);
      wait_for(2, 1'b0, 8);
      rd(`OFS_EVT_STATUS, 8'h03);
   endtask : idle_case

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_values();
      phase_case();
      eye_case();
      mute_case();
      buffer_case();
      idle_case();
      end_of_test();
   end
endmodule : tb_top
